// File: rtl/scc_pkg.sv
// Shared constants and types of the spread clock control block
package scc_pkg;

  // ----------------------------------------------------------------
  // Serial slave identity and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h6a;
  localparam logic [7:0] REG_SPREAD = 8'h00;
  localparam logic [7:0] REG_OUTEN  = 8'h01;
  localparam logic [7:0] REG_IDENT  = 8'h06;
  localparam logic [7:0] REG_COUNT  = 8'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B0_SEL0  = 7;
  localparam int B0_SEL1  = 6;
  localparam int B0_SEL2  = 5;
  localparam int B0_SEL3  = 4;
  localparam int B0_FREQ  = 3;
  localparam int B0_RSVD  = 2;
  localparam int B0_SPREN = 1;
  localparam int B0_SWCTL = 0;
  localparam int B1_OE    = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_SEL   = 4'h0;
  localparam logic       RST_FREQ  = 1'b0;
  localparam logic       RST_SPREN = 1'b1;
  localparam logic       RST_SWCTL = 1'b0;
  localparam logic       RST_OE    = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real SETTLE_TIME_MS     = 3.0;
  localparam int  MCLK_FREQ_KHZ      = 125000;
  localparam int  SETTLE_CYCLES      = int'(SETTLE_TIME_MS * MCLK_FREQ_KHZ);
  localparam int  REF_TIMEOUT_CYCLES = 16;
  localparam int  PD_OUT_PERIODS     = 2;
  // Output toggles on every rising reference edge, so one period is two such edges
  localparam int  REF_PER_OUT        = 2;

  // ----------------------------------------------------------------
  // Serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_RX    = 3'b010,
    ST_ACK1  = 3'b011,
    ST_ACK2  = 3'b100,
    ST_TX    = 3'b101,
    ST_TXACK = 3'b110
  } scc_state_t;

endpackage

// File: rtl/scc_spread_ctrl.sv
// Control registers, serial slave and power-down sequencing of the spread clock block
`timescale 1ns/1ps
module scc_spread_ctrl #(
  parameter int         SETTLE_CYCLES = scc_pkg::SETTLE_CYCLES,
  parameter int         REF_TIMEOUT   = scc_pkg::REF_TIMEOUT_CYCLES,
  parameter int         PD_PERIODS    = scc_pkg::PD_OUT_PERIODS,
  // Identification values are arbitrary
  parameter logic [3:0] REVISION_ID   = 4'h1,
  parameter logic [3:0] VENDOR_ID     = 4'h5
) (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // Reference clock domain
  input  wire logic       reference_clock_input,
  // Pins
  input  wire logic       power_down_pin,
  input  wire logic [3:1] spread_strap_pin,
  input  wire logic       frequency_strap_pin,
  // Serial bus
  input  wire logic       smbus_clk,
  input  wire logic       smbus_dat_in,
  output logic            smbus_dat_out,
  output logic            smbus_dat_oe_n,
  // Differential output
  output logic            diff_clock_output_p,
  output logic            diff_clock_output_n,
  output logic            diff_clock_output_oe_n,
  // Status
  output logic [3:0]      spread_code,
  output logic            spread_down_type,
  output logic            spread_on,
  output logic            freq_100mhz,
  output logic            clock_stable
);

  localparam int SW     = $clog2(SETTLE_CYCLES + 1);
  localparam int PD_REF = PD_PERIODS * scc_pkg::REF_PER_OUT;

  generate
    if (SETTLE_CYCLES < 1 || REF_TIMEOUT < 2 || REF_TIMEOUT > 255 ||
        PD_PERIODS < 1 || PD_REF > 255) begin : g_bad_param
      $error("scc_spread_ctrl: parameter out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Synchronisers into mclk
  // ----------------------------------------------------------------
  logic       scl_s1_q, scl_s2_q, scl_s3_q;
  logic       sda_s1_q, sda_s2_q, sda_s3_q;
  logic       pdm_s1_q, pdm_s2_q;
  logic       hb_s1_q, hb_s2_q, hb_s3_q;
  logic       hb_q;
  logic [3:1] strap_s1_q, strap_s2_q;
  logic       freq_s1_q, freq_s2_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      {pdm_s1_q, pdm_s2_q}           <= 2'h0;
      {hb_s1_q, hb_s2_q, hb_s3_q}    <= 3'h0;
      strap_s1_q                     <= 3'h0;
      strap_s2_q                     <= 3'h0;
      {freq_s1_q, freq_s2_q}         <= 2'h0;
    end else begin
      scl_s1_q   <= smbus_clk;
      scl_s2_q   <= scl_s1_q;
      scl_s3_q   <= scl_s2_q;
      sda_s1_q   <= smbus_dat_in;
      sda_s2_q   <= sda_s1_q;
      sda_s3_q   <= sda_s2_q;
      pdm_s1_q   <= power_down_pin;
      pdm_s2_q   <= pdm_s1_q;
      hb_s1_q    <= hb_q;
      hb_s2_q    <= hb_s1_q;
      hb_s3_q    <= hb_s2_q;
      strap_s1_q <= spread_strap_pin;
      strap_s2_q <= strap_s1_q;
      freq_s1_q  <= frequency_strap_pin;
      freq_s2_q  <= freq_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  logic       scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] rx_byte, shift_q, ptr_q;

  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign rx_byte   = {shift_q[6:0], sda_s2_q};

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [3:0] sel_q;
  logic       freq_q, rsvd_q, spren_q, swctl_q, oe_q;
  logic       wr_stb_q;
  logic [7:0] wr_addr_q, wr_data_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q   <= scc_pkg::RST_SEL;
      freq_q  <= scc_pkg::RST_FREQ;
      rsvd_q  <= 1'b0;
      spren_q <= scc_pkg::RST_SPREN;
      swctl_q <= scc_pkg::RST_SWCTL;
      oe_q    <= scc_pkg::RST_OE;
    end else if (clk_en) begin
      if (!swctl_q) begin
        sel_q  <= {strap_s2_q, 1'b0};
        freq_q <= freq_s2_q;
      end
      if (wr_stb_q) begin
        case (wr_addr_q)
          scc_pkg::REG_SPREAD: begin
            swctl_q <= wr_data_q[scc_pkg::B0_SWCTL];
            rsvd_q  <= wr_data_q[scc_pkg::B0_RSVD];
            if (swctl_q) begin
              sel_q   <= {wr_data_q[scc_pkg::B0_SEL3], wr_data_q[scc_pkg::B0_SEL2],
                          wr_data_q[scc_pkg::B0_SEL1], wr_data_q[scc_pkg::B0_SEL0]};
              freq_q  <= wr_data_q[scc_pkg::B0_FREQ];
              spren_q <= wr_data_q[scc_pkg::B0_SPREN];
            end
          end
          scc_pkg::REG_OUTEN: oe_q <= wr_data_q[scc_pkg::B1_OE];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    case (ptr_q)
      scc_pkg::REG_SPREAD: begin
        if (!swctl_q) begin
          rd_byte[scc_pkg::B0_SEL0] = 1'b0;
          rd_byte[scc_pkg::B0_SEL1] = strap_s2_q[1];
          rd_byte[scc_pkg::B0_SEL2] = strap_s2_q[2];
          rd_byte[scc_pkg::B0_SEL3] = strap_s2_q[3];
          rd_byte[scc_pkg::B0_FREQ] = freq_s2_q;
        end else begin
          rd_byte[scc_pkg::B0_SEL0] = sel_q[0];
          rd_byte[scc_pkg::B0_SEL1] = sel_q[1];
          rd_byte[scc_pkg::B0_SEL2] = sel_q[2];
          rd_byte[scc_pkg::B0_SEL3] = sel_q[3];
          rd_byte[scc_pkg::B0_FREQ] = freq_q;
        end
        rd_byte[scc_pkg::B0_RSVD]  = rsvd_q;
        rd_byte[scc_pkg::B0_SPREN] = spren_q;
        rd_byte[scc_pkg::B0_SWCTL] = swctl_q;
      end
      scc_pkg::REG_OUTEN: rd_byte[scc_pkg::B1_OE] = oe_q;
      scc_pkg::REG_IDENT: rd_byte = {REVISION_ID, VENDOR_ID};
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial slave engine
  // ----------------------------------------------------------------
  scc_pkg::scc_state_t state_q;
  logic [3:0] bit_q;
  logic [1:0] idx_q;
  logic       rw_q, drive_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= scc_pkg::ST_IDLE;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      bit_q     <= 4'h0;
      idx_q     <= 2'h0;
      rw_q      <= 1'b0;
      drive_q   <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else if (clk_en) begin
      wr_stb_q <= 1'b0;
      if (pdm_s2_q) begin
        state_q <= scc_pkg::ST_IDLE;
        drive_q <= 1'b0;
      end else if (bus_start) begin
        state_q <= scc_pkg::ST_ADDR;
        bit_q   <= 4'h0;
        drive_q <= 1'b0;
      end else if (bus_stop) begin
        state_q <= scc_pkg::ST_IDLE;
        drive_q <= 1'b0;
      end else begin
        case (state_q)
          scc_pkg::ST_ADDR, scc_pkg::ST_RX: begin
            if (scl_rise) begin
              shift_q <= rx_byte;
              bit_q   <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                bit_q <= 4'h0;
                if (state_q == scc_pkg::ST_ADDR) begin
                  if (rx_byte[7:1] == scc_pkg::SLAVE_ADDR) begin
                    rw_q    <= rx_byte[0];
                    idx_q   <= 2'h0;
                    state_q <= scc_pkg::ST_ACK1;
                  end else begin
                    state_q <= scc_pkg::ST_IDLE;
                  end
                end else begin
                  state_q <= scc_pkg::ST_ACK1;
                  if (idx_q != 2'h2) begin
                    idx_q <= idx_q + 2'h1;
                  end
                  if (idx_q == 2'h0) begin
                    ptr_q <= rx_byte;
                  end else if (idx_q == 2'h2) begin
                    wr_stb_q  <= 1'b1;
                    wr_addr_q <= ptr_q;
                    wr_data_q <= rx_byte;
                    ptr_q     <= ptr_q + 8'h01;
                  end
                end
              end
            end
          end
          scc_pkg::ST_ACK1: begin
            if (scl_fall) begin
              drive_q <= 1'b1;
              state_q <= scc_pkg::ST_ACK2;
            end
          end
          scc_pkg::ST_ACK2: begin
            if (scl_fall) begin
              if (rw_q) begin
                drive_q <= ~scc_pkg::REG_COUNT[7];
                shift_q <= {scc_pkg::REG_COUNT[6:0], 1'b0};
                bit_q   <= 4'h1;
                state_q <= scc_pkg::ST_TX;
              end else begin
                drive_q <= 1'b0;
                bit_q   <= 4'h0;
                state_q <= scc_pkg::ST_RX;
              end
            end
          end
          scc_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                drive_q <= 1'b0;
                state_q <= scc_pkg::ST_TXACK;
              end else begin
                drive_q <= ~shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
                bit_q   <= bit_q + 4'h1;
              end
            end
          end
          scc_pkg::ST_TXACK: begin
            if (scl_rise) begin
              if (sda_s2_q) begin
                state_q <= scc_pkg::ST_IDLE;
              end else begin
                shift_q <= rd_byte;
                ptr_q   <= ptr_q + 8'h01;
                bit_q   <= 4'h0;
                state_q <= scc_pkg::ST_TX;
              end
            end
          end
          default: state_q <= scc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain data: only ever pulls low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      smbus_dat_out  <= 1'b0;
      smbus_dat_oe_n <= 1'b1;
    end else if (clk_en) begin
      smbus_dat_out  <= 1'b0;
      smbus_dat_oe_n <= ~(drive_q & ~pdm_s2_q);
    end
  end

  // ----------------------------------------------------------------
  // Effective settings and settling
  // ----------------------------------------------------------------
  logic          cfg_change, ref_alive_q;
  logic [7:0]    ref_tmr_q;
  logic [SW-1:0] settle_q;

  assign cfg_change = {sel_q, spren_q, freq_q} != {spread_code, spread_on, freq_100mhz};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      spread_code      <= scc_pkg::RST_SEL;
      spread_down_type <= 1'b1;
      spread_on        <= scc_pkg::RST_SPREN;
      freq_100mhz      <= scc_pkg::RST_FREQ;
    end else if (clk_en) begin
      spread_code      <= sel_q;
      spread_down_type <= ~sel_q[3];
      spread_on        <= spren_q;
      freq_100mhz      <= freq_q;
    end
  end

  // A stopped reference leaves the heartbeat still; the timeout notices
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ref_tmr_q   <= 8'h00;
      ref_alive_q <= 1'b0;
    end else if (clk_en) begin
      if (hb_s2_q != hb_s3_q) begin
        ref_tmr_q   <= 8'h00;
        ref_alive_q <= 1'b1;
      end else if (ref_tmr_q == 8'(REF_TIMEOUT)) begin
        ref_alive_q <= 1'b0;
      end else begin
        ref_tmr_q <= ref_tmr_q + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      settle_q     <= '0;
      clock_stable <= 1'b0;
    end else if (clk_en) begin
      if (pdm_s2_q || !ref_alive_q || cfg_change) begin
        settle_q <= '0;
      end else if (settle_q != SW'(SETTLE_CYCLES)) begin
        settle_q <= settle_q + SW'(1);
      end
      clock_stable <= (settle_q == SW'(SETTLE_CYCLES)) & ~cfg_change;
    end
  end

  // ----------------------------------------------------------------
  // Reference clock domain: output gating
  // ----------------------------------------------------------------
  logic       pdr_s1_q, pdr_s2_q, cer_s1_q, cer_s2_q, oer_s1_q, oer_s2_q;
  logic       stop_req;
  logic [7:0] pd_cnt_q;

  always_ff @(posedge reference_clock_input or negedge reset_n) begin
    if (!reset_n) begin
      {pdr_s1_q, pdr_s2_q} <= 2'h0;
      {cer_s1_q, cer_s2_q} <= 2'h0;
      {oer_s1_q, oer_s2_q} <= 2'h0;
    end else begin
      pdr_s1_q <= power_down_pin;
      pdr_s2_q <= pdr_s1_q;
      cer_s1_q <= clk_en;
      cer_s2_q <= cer_s1_q;
      oer_s1_q <= oe_q;
      oer_s2_q <= oer_s1_q;
    end
  end

  assign stop_req = (pd_cnt_q == 8'(PD_REF)) | ~oer_s2_q;

  always_ff @(posedge reference_clock_input or negedge reset_n) begin
    if (!reset_n) begin
      hb_q     <= 1'b0;
      pd_cnt_q <= 8'h00;
    end else if (cer_s2_q) begin
      hb_q <= ~hb_q;
      if (!pdr_s2_q) begin
        pd_cnt_q <= 8'h00;
      end else if (pd_cnt_q != 8'(PD_REF)) begin
        pd_cnt_q <= pd_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge reference_clock_input or negedge reset_n) begin
    if (!reset_n) begin
      diff_clock_output_p    <= 1'b0;
      diff_clock_output_n    <= 1'b1;
      diff_clock_output_oe_n <= 1'b1;
    end else if (cer_s2_q) begin
      if (!stop_req) begin
        diff_clock_output_p    <= ~diff_clock_output_p;
        diff_clock_output_n    <= diff_clock_output_p;
        diff_clock_output_oe_n <= 1'b0;
      end else if (diff_clock_output_p) begin
        diff_clock_output_p <= 1'b0;
        diff_clock_output_n <= 1'b1;
      end else begin
        diff_clock_output_oe_n <= 1'b1;
      end
    end
  end

endmodule // scc_spread_ctrl

// File: bench/scc_spread_ctrl_asserts.sv
// Port-level checks of the spread clock control block
`timescale 1ns/1ps
module scc_spread_ctrl_asserts #(
  parameter int SETTLE_CYCLES = 50
) (
  // Clocks and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       reference_clock_input,
  // Pins
  input wire logic       power_down_pin,
  input wire logic       smbus_dat_oe_n,
  input wire logic       diff_clock_output_p,
  input wire logic       diff_clock_output_n,
  input wire logic       diff_clock_output_oe_n,
  // Status
  input wire logic [3:0] spread_code,
  input wire logic       spread_down_type,
  input wire logic       spread_on,
  input wire logic       freq_100mhz,
  input wire logic       clock_stable
);
  logic [7:0]  pd_cnt_q;
  logic [31:0] low_cnt_q;

  // Cycles with power-down high, and cycles with the stable flag low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) pd_cnt_q <= 8'h00;
    else if (!power_down_pin) pd_cnt_q <= 8'h00;
    else if (pd_cnt_q != 8'hff) pd_cnt_q <= pd_cnt_q + 8'h01;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) low_cnt_q <= 32'h0;
    else if (clock_stable) low_cnt_q <= 32'h0;
    else low_cnt_q <= low_cnt_q + 32'h1;
  end

  pd_output_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pd_cnt_q >= 8'h28 |-> diff_clock_output_oe_n) else $error("output driven in power-down");
  pd_serial_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pd_cnt_q >= 8'h08 |-> smbus_dat_oe_n) else $error("serial data driven in power-down");
  clean_stop_a: assert property (@(posedge reference_clock_input) disable iff (!reset_n)
    $rose(diff_clock_output_oe_n) |-> !diff_clock_output_p && diff_clock_output_n
      && !$past(diff_clock_output_p)) else $error("output stopped outside low phase");
  drive_diff_a: assert property (@(posedge reference_clock_input) disable iff (!reset_n)
    !diff_clock_output_oe_n |-> diff_clock_output_p != diff_clock_output_n)
    else $error("output pair not complementary");
  type_map_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $stable(spread_code) |-> spread_down_type == !spread_code[3]) else $error("spread type wrong");
  settle_drop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ($changed(spread_code) || $changed(spread_on) || $changed(freq_100mhz)) |-> ##[0:2]
      !clock_stable) else $error("stable kept after setting change");
  settle_time_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(clock_stable) |-> low_cnt_q >= 32'(SETTLE_CYCLES)) else $error("settle too short");
  pd_unstable_a: assert property (@(posedge mclk) disable iff (!reset_n)
    power_down_pin [*6] |-> !clock_stable) else $error("stable high in power-down");
endmodule // scc_spread_ctrl_asserts

// File: bench/scc_smbus_host.sv
// Serial bus host model for the spread clock control block
`timescale 1ns/1ps
module scc_smbus_host (
  // Clock
  input  wire logic mclk,
  // Serial lines, data is open drain
  output logic      scl,
  output logic      sda_o,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Also used as repeated start, so data is raised first while the clock is low
  task automatic start_cond();
    sda_o <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(12);
    sda_o <= 1'b0;
    tick(12);
    scl <= 1'b0;
    tick(8);
  endtask
  task automatic stop_cond();
    sda_o <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(12);
    sda_o <= 1'b1;
    tick(12);
  endtask
  // Low phase of 14 cycles leaves the slave its synchroniser delay
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    tick(6);
    scl <= 1'b1;
    tick(5);
    @(negedge mclk);
    r = sda;
    tick(7);
    scl <= 1'b0;
    tick(8);
  endtask
  task automatic byte_x(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                        output logic a_out);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a_in, a_out);
  endtask
  task automatic send(input logic [7:0] d, inout logic ok);
    logic [7:0] q;
    logic       a;
    byte_x(d, 1'b1, q, a);
    ok = ok & !a;
  endtask
  task automatic probe(input logic [7:0] a, output logic ok);
    ok = 1'b1;
    start_cond();
    send(a, ok);
    stop_cond();
  endtask
  // write address, then offset and count before the data
  task automatic write_regs(input logic [7:0] n, input int cnt, input logic [7:0] d0,
                            input logic [7:0] d1, output logic ok);
    ok = 1'b1;
    start_cond();
    send(8'hd4, ok);
    send(n, ok);
    send(8'(cnt), ok);
    send(d0, ok);
    if (cnt == 2) send(d1, ok);
    stop_cond();
  endtask
  // read address after a repeated start; last byte is not acknowledged
  task automatic read_regs(input logic [7:0] n, input int cnt, output logic [7:0] q [$],
                           output logic ok);
    logic [7:0] b;
    logic       a;
    q = {};
    ok = 1'b1;
    start_cond();
    send(8'hd4, ok);
    send(n, ok);
    start_cond();
    send(8'hd5, ok);
    for (int i = 0; i <= cnt; i++) begin
      byte_x(8'hff, i == cnt, b, a);
      q.push_back(b);
    end
    stop_cond();
  endtask
endmodule // scc_smbus_host

// File: bench/scc_spread_ctrl_tb_top.sv
// Self-checking bench of the spread clock control block
`timescale 1ns/1ps
module scc_spread_ctrl_tb_top;
  localparam int SETTLE = 50;
  logic       mclk = 1'b0;
  logic       ref_clk = 1'b0;
  logic       ref_run = 1'b1;
  logic       reset_n = 1'b0;
  logic       clk_en = 1'b1;
  logic       pd = 1'b0;
  logic [3:1] straps = 3'b101;
  logic       freq_pin = 1'b1;
  logic       scl, host_sda_o, dat_out, dat_oe_n, clk_p, clk_n, clk_oe_n;
  logic       down_t, spr_on, f100, stable, ok, hold_p;
  logic [3:0] code;
  wire logic  sda_w;
  logic [7:0] q [$];
  logic [7:0] wv [3] = '{8'h89, 8'h7b, 8'hf1};
  logic [7:0] map [6] = '{8'h5a, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  int         bad_count = 0;
  int         n_compared = 0;

  always #4 mclk = ~mclk;
  // reference runs except where a scenario stops it
  initial begin
    #1.7;
    forever #6 if (ref_run) ref_clk = ~ref_clk;
  end
  // Pull-up on the data line
  assign sda_w = host_sda_o & (dat_oe_n | dat_out);

  scc_spread_ctrl #(.SETTLE_CYCLES(SETTLE), .REVISION_ID(4'h1), .VENDOR_ID(4'h5)) u_dut (
    .mclk, .reset_n, .clk_en, .reference_clock_input(ref_clk), .power_down_pin(pd),
    .spread_strap_pin(straps), .frequency_strap_pin(freq_pin), .smbus_clk(scl),
    .smbus_dat_in(sda_w), .smbus_dat_out(dat_out), .smbus_dat_oe_n(dat_oe_n),
    .diff_clock_output_p(clk_p), .diff_clock_output_n(clk_n), .diff_clock_output_oe_n(clk_oe_n),
    .spread_code(code), .spread_down_type(down_t), .spread_on(spr_on), .freq_100mhz(f100),
    .clock_stable(stable));
  scc_smbus_host u_host (.mclk, .scl, .sda_o(host_sda_o), .sda(sda_w));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic wait_stable(input int lim);
    for (int i = 0; i < lim && stable !== 1'b1; i++) @(posedge mclk);
    chk("clock_stable", 8'h01, {7'h0, stable});
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (12) @(posedge mclk);
    chk("spread_code", 8'h0a, {4'h0, code});
    chk("down_type", 8'h00, {7'h0, down_t});
    chk("spread_on", 8'h01, {7'h0, spr_on});
    chk("freq_100mhz", 8'h01, {7'h0, f100});
    wait_stable(SETTLE + 40);
    u_host.read_regs(8'h00, 7, q, ok);
    chk("read_ack", 8'h01, {7'h0, ok});
    chk("count", 8'h07, q[0]);
    for (int i = 0; i < 6; i++) chk("reg", map[i], q[i + 1]);
    chk("ident", 8'h15, q[7]);
    // Pin mode: select bits ignore writes and follow the straps
    u_host.write_regs(8'h00, 1, 8'hf8, 8'h00, ok);
    straps <= 3'b010;
    freq_pin <= 1'b0;
    u_host.read_regs(8'h00, 1, q, ok);
    chk("pin_byte0", 8'h22, q[1]);
    chk("pin_code", 8'h04, {4'h0, code});
    u_host.write_regs(8'h00, 1, 8'h01, 8'h00, ok);
    foreach (wv[i]) begin
      u_host.write_regs(8'h00, 1, wv[i], 8'h00, ok);
      u_host.read_regs(8'h00, 1, q, ok);
      chk("sw_byte0", wv[i], q[1]);
      chk("sw_code", {4'h0, wv[i][4], wv[i][5], wv[i][6], wv[i][7]}, {4'h0, code});
      chk("sw_freq", {7'h0, wv[i][3]}, {7'h0, f100});
      chk("sw_spread", {7'h0, wv[i][1]}, {7'h0, spr_on});
      chk("sw_type", {7'h0, ~wv[i][4]}, {7'h0, down_t});
    end
    wait_stable(SETTLE + 40);
    u_host.write_regs(8'h01, 2, 8'h00, 8'h00, ok);
    u_host.write_regs(8'h06, 1, 8'h00, 8'h00, ok);
    chk("oe_off", 8'h01, {7'h0, clk_oe_n});
    u_host.read_regs(8'h06, 1, q, ok);
    chk("ident_ro", 8'h15, q[1]);
    u_host.write_regs(8'h01, 1, 8'h04, 8'h00, ok);
    repeat (20) @(posedge mclk);
    chk("oe_on", 8'h00, {7'h0, clk_oe_n});
    // Clock enable low freezes the output pair
    clk_en <= 1'b0;
    repeat (10) @(posedge mclk);
    hold_p = clk_p;
    repeat (20) @(posedge mclk);
    chk("en_freeze", {7'h0, hold_p}, {7'h0, clk_p});
    clk_en <= 1'b1;
    repeat (4) @(posedge mclk);
    u_host.probe(8'ha4, ok);
    chk("bad_addr", 8'h00, {7'h0, ok});
    // Power-down, then release with the reference stopped
    pd <= 1'b1;
    repeat (60) @(posedge mclk);
    chk("pd_clk_oe", 8'h01, {7'h0, clk_oe_n});
    u_host.probe(8'hd4, ok);
    chk("pd_bus", 8'h00, {7'h0, ok});
    ref_run <= 1'b0;
    pd <= 1'b0;
    repeat (SETTLE + 40) @(posedge mclk);
    chk("no_ref_stable", 8'h00, {7'h0, stable});
    ref_run <= 1'b1;
    wait_stable(SETTLE + 80);
    chk("release_oe", 8'h00, {7'h0, clk_oe_n});
    report_and_stop();
  end

  initial begin
    #800000;
    bad_count++;
    report_and_stop();
  end
endmodule // scc_spread_ctrl_tb_top

bind scc_spread_ctrl scc_spread_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .mclk, .reset_n, .reference_clock_input, .power_down_pin, .smbus_dat_oe_n,
  .diff_clock_output_p, .diff_clock_output_n, .diff_clock_output_oe_n, .spread_code,
  .spread_down_type, .spread_on, .freq_100mhz, .clock_stable);
